/* File: core/tlpec_pkg.sv */
package tlpec_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_SEVERITY = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0c;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CTL_MPS_LSB = 0;
	localparam int CTL_MAP_LSB = 4;
	localparam int CTL_D3HOT_BIT = 12;
	localparam int CTL_LINKUP_BIT = 13;
	localparam int CTL_DSPORT_BIT = 14;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_2010;

	// ----------------------------------------
	// severity register fields
	// ----------------------------------------
	localparam int SEV_UC_BIT = 0;
	localparam int SEV_UR_BIT = 1;
	localparam int SEV_FN_LSB = 8;
	localparam logic [31:0] SEVERITY_RESET = 32'h0000_0003;

	// ----------------------------------------
	// status register fields (write one to clear)
	// ----------------------------------------
	localparam int STS_PRI_STA_BIT = 0;
	localparam int STS_SEC_STA_BIT = 1;

	// ----------------------------------------
	// header field codes
	// ----------------------------------------
	localparam logic [4:0] TYPE_MEM = 5'h00;
	localparam logic [4:0] TYPE_MEMLK = 5'h01;
	localparam logic [4:0] TYPE_IO = 5'h02;
	localparam logic [4:0] TYPE_CFG0 = 5'h04;
	localparam logic [4:0] TYPE_CFG1 = 5'h05;
	localparam logic [4:0] TYPE_CPL = 5'h0a;
	localparam logic [4:0] TYPE_CPLLK = 5'h0b;
	localparam logic [7:0] MSG_VENDOR0 = 8'h7e;
	localparam logic [7:0] MSG_VENDOR1 = 8'h7f;

	// ----------------------------------------
	// error types on the report strobe
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		TLPEC_ERR_NONE,
		TLPEC_ERR_UNEXP_CPL,
		TLPEC_ERR_OVERFLOW,
		TLPEC_ERR_MALFORMED,
		TLPEC_ERR_MCAST_BLOCK,
		TLPEC_ERR_ECRC,
		TLPEC_ERR_UNSUPPORTED
	} tlpec_err_t;

	typedef enum logic [1:0]
	{
		TLPEC_ACT_PASS,
		TLPEC_ACT_DROP,
		TLPEC_ACT_NULLIFY,
		TLPEC_ACT_UR_CPL
	} tlpec_act_t;

endpackage

/* File: core/tlpec_checker.sv */
// Notes on behaviour
// - unmatched completion is dropped and its header logged
// - unmatched completion: correctable if severity non-fatal, else uncorrectable
// - receive overflow: uncorrectable, nullified, header not logged
// - flow control protocol errors are never detected
// - malformed packet: uncorrectable, header logged, nullified
// - multicast block sets target abort flag on receiving side, uncorrectable, logged, nullified
// - port end-to-end crc checking on when any port function enables it
// - port checking on: verify crc of every packet with digest bit
// - crc errors reported only for functions with checking enabled
// - vendor type 0 message to bridge is an unsupported request
// - vendor type 1 message to bridge is silently dropped
// - message with invalid code to bridge is an unsupported request
// - poisoned io, memory write or non-vendor data message to bridge is unsupported
// - requests to function in d3hot are unsupported requests
// - downstream port with link down: downstream packets are unsupported
// - invalid format and type combination is malformed
// - payload over max payload size is malformed
// - packets with data: length field differing from payload is malformed
// - digest packets: total length not header plus payload plus crc is malformed
// - io and config requests need length one, tc and attr zero, last be zero
// - packets with physical or link layer error raise no transaction errors
// - traffic class not mapped to channel 0 is malformed
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module tlpec_checker #(
	parameter int FUNCS = 4
)
(
	input wire logic clk,
	input wire logic reset_n,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// received packet descriptor, one cycle per packet
	input wire logic pkt_valid,
	input wire logic [2:0] pkt_fmt,
	input wire logic [4:0] pkt_type,
	input wire logic [2:0] pkt_tc,
	input wire logic [1:0] pkt_attr,
	input wire logic pkt_digest,
	input wire logic pkt_poisoned,
	input wire logic [9:0] pkt_length,
	input wire logic [3:0] pkt_last_be,
	input wire logic [7:0] pkt_msg_code,
	input wire logic [12:0] pkt_payload_bytes,
	input wire logic [12:0] pkt_total_bytes,
	input wire logic pkt_secondary,
	input wire logic pkt_downstream,
	input wire logic pkt_to_bridge,
	input wire logic [FUNCS-1:0] pkt_func,
	input wire logic pkt_lower_err,
	input wire logic pkt_cpl_unmatched,
	input wire logic pkt_overflow,
	input wire logic pkt_mcast_blocked,
	input wire logic pkt_msg_code_ok,
	input wire logic pkt_ecrc_bad,
	// result and error strobe
	output logic res_valid,
	output logic [1:0] res_action,
	output logic err_valid,
	output logic [2:0] err_type,
	output logic err_uncorrectable,
	output logic err_log_header,
	output logic ecrc_port_enable
);

	// select and enable fields hold at most eight functions
	if (FUNCS < 1 || FUNCS > 8)
	begin : g_bad_funcs
		$error("FUNCS must be 1 to 8");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0] control;
	logic [31:0] severity;
	logic primary_sta;
	logic secondary_sta;
	logic [15:0] err_count;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return a[7:2] == b[7:2];
	endfunction

	// ----------------------------------------
	// axi write path
	// ----------------------------------------
	logic wr_go;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_bresp = 2'h0;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			control <= tlpec_pkg::CONTROL_RESET;
			severity <= tlpec_pkg::SEVERITY_RESET;
		end
		else if (wr_go)
		begin
			if (hit(aw_addr, tlpec_pkg::ADDR_CONTROL))
				control <= merge(control, w_data, w_strb);
			else if (hit(aw_addr, tlpec_pkg::ADDR_SEVERITY))
				severity <= merge(severity, w_data, w_strb);
		end
	end

	// ----------------------------------------
	// axi read path
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp = 2'h0;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			if (hit(s_axi_araddr, tlpec_pkg::ADDR_CONTROL))
				s_axi_rdata <= control;
			else if (hit(s_axi_araddr, tlpec_pkg::ADDR_SEVERITY))
				s_axi_rdata <= severity;
			else if (hit(s_axi_araddr, tlpec_pkg::ADDR_STATUS))
				s_axi_rdata <= {30'h0, secondary_sta, primary_sta};
			else if (hit(s_axi_araddr, tlpec_pkg::ADDR_COUNT))
				s_axi_rdata <= {16'h0000, err_count};
			else
				s_axi_rdata <= 32'h0000_0000;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	logic [2:0] mps_code;
	logic [7:0] class_to_channel_map;
	logic [FUNCS-1:0] func_ecrc_en;
	logic [12:0] max_payload;
	assign mps_code = control[tlpec_pkg::CTL_MPS_LSB +: 3];
	assign class_to_channel_map = control[tlpec_pkg::CTL_MAP_LSB +: 8];
	assign func_ecrc_en = severity[tlpec_pkg::SEV_FN_LSB +: FUNCS];
	// mps codes above 5 are reserved; clamp to 4096
	assign max_payload = (mps_code > 3'h5) ? 13'h1000 : 13'(13'h0080 << mps_code);

	assign ecrc_port_enable = |func_ecrc_en;

	// ----------------------------------------
	// formation checks
	// ----------------------------------------
	logic has_data;
	logic is_msg;
	logic is_io_cfg;
	logic fmt_type_ok;
	logic malformed;
	logic [12:0] hdr_bytes;
	logic [12:0] len_bytes;

	assign has_data = pkt_fmt[1];
	assign is_msg = pkt_type[4:3] == 2'h2;
	assign is_io_cfg = pkt_type == tlpec_pkg::TYPE_IO || pkt_type == tlpec_pkg::TYPE_CFG0
		|| pkt_type == tlpec_pkg::TYPE_CFG1;
	assign hdr_bytes = pkt_fmt[0] ? 13'h010 : 13'h00c;
	// a zero length field means 1024 doublewords
	assign len_bytes = {(pkt_length == 10'h000), pkt_length, 2'h0};

	always_comb
	begin
		fmt_type_ok = 1'b0;
		if (pkt_type == tlpec_pkg::TYPE_MEM)
			fmt_type_ok = !pkt_fmt[2];
		else if (pkt_type == tlpec_pkg::TYPE_MEMLK)
			fmt_type_ok = pkt_fmt[2:1] == 2'h0;
		else if (is_io_cfg)
			fmt_type_ok = pkt_fmt == 3'h0 || pkt_fmt == 3'h2;
		else if (is_msg)
			fmt_type_ok = !pkt_fmt[2] && pkt_fmt[0];
		else if (pkt_type == tlpec_pkg::TYPE_CPL || pkt_type == tlpec_pkg::TYPE_CPLLK)
			fmt_type_ok = pkt_fmt[2] == 1'b0 && pkt_fmt[0] == 1'b0;
		malformed = !fmt_type_ok;
		if (has_data && pkt_payload_bytes > max_payload)
			malformed = 1'b1;
		if (has_data && len_bytes != pkt_payload_bytes)
			malformed = 1'b1;
		if (pkt_digest && pkt_total_bytes != 13'(hdr_bytes + pkt_payload_bytes + 13'h004))
			malformed = 1'b1;
		if (is_io_cfg && (pkt_length != 10'h001 || pkt_tc != 3'h0 || pkt_attr != 2'h0
			|| pkt_last_be != 4'h0))
			malformed = 1'b1;
		// tc must map to channel 0
		if (!class_to_channel_map[pkt_tc])
			malformed = 1'b1;
	end

	// ----------------------------------------
	// classification, fixed priority
	// ----------------------------------------
	logic vendor0;
	logic vendor1;
	logic is_posted_wr;
	logic unsupported;
	logic ecrc_fail;
	tlpec_pkg::tlpec_err_t next_type;
	tlpec_pkg::tlpec_act_t next_action;
	logic next_unc;
	logic next_log;

	assign vendor0 = is_msg && pkt_msg_code == tlpec_pkg::MSG_VENDOR0;
	assign vendor1 = is_msg && pkt_msg_code == tlpec_pkg::MSG_VENDOR1;
	assign is_posted_wr = (pkt_type == tlpec_pkg::TYPE_MEM && has_data)
		|| pkt_type == tlpec_pkg::TYPE_IO || (is_msg && has_data && !vendor0 && !vendor1);
	assign ecrc_fail = ecrc_port_enable && pkt_digest && pkt_ecrc_bad
		&& |(pkt_func & func_ecrc_en);

	always_comb
	begin
		unsupported = 1'b0;
		if (control[tlpec_pkg::CTL_D3HOT_BIT] && pkt_to_bridge && pkt_type[4:1] != 4'h5)
			unsupported = 1'b1;
		if (control[tlpec_pkg::CTL_DSPORT_BIT] && !control[tlpec_pkg::CTL_LINKUP_BIT]
			&& pkt_downstream)
			unsupported = 1'b1;
		if (pkt_to_bridge)
		begin
			if (vendor0)
				unsupported = 1'b1;
			if (is_msg && !vendor1 && !pkt_msg_code_ok)
				unsupported = 1'b1;
			if (pkt_poisoned && is_posted_wr)
				unsupported = 1'b1;
		end
	end

	always_comb
	begin
		next_type = tlpec_pkg::TLPEC_ERR_NONE;
		next_action = tlpec_pkg::TLPEC_ACT_PASS;
		next_unc = 1'b0;
		next_log = 1'b0;
		if (pkt_lower_err)
			next_action = tlpec_pkg::TLPEC_ACT_DROP;
		else if (pkt_overflow)
		begin
			next_type = tlpec_pkg::TLPEC_ERR_OVERFLOW;
			next_action = tlpec_pkg::TLPEC_ACT_NULLIFY;
			next_unc = 1'b1;
		end
		else if (malformed)
		begin
			next_type = tlpec_pkg::TLPEC_ERR_MALFORMED;
			next_action = tlpec_pkg::TLPEC_ACT_NULLIFY;
			next_unc = 1'b1;
			next_log = 1'b1;
		end
		else if (pkt_mcast_blocked)
		begin
			next_type = tlpec_pkg::TLPEC_ERR_MCAST_BLOCK;
			next_action = tlpec_pkg::TLPEC_ACT_NULLIFY;
			next_unc = 1'b1;
			next_log = 1'b1;
		end
		else if (pkt_cpl_unmatched && !pkt_fmt[2] && pkt_type[4:1] == 4'h5)
		begin
			next_type = tlpec_pkg::TLPEC_ERR_UNEXP_CPL;
			next_action = tlpec_pkg::TLPEC_ACT_DROP;
			next_log = 1'b1;
			next_unc = severity[tlpec_pkg::SEV_UC_BIT];
		end
		else if (unsupported)
		begin
			next_type = tlpec_pkg::TLPEC_ERR_UNSUPPORTED;
			next_action = has_data && !is_io_cfg ? tlpec_pkg::TLPEC_ACT_DROP
				: tlpec_pkg::TLPEC_ACT_UR_CPL;
			next_log = 1'b1;
			// non-posted may be advisory
			next_unc = severity[tlpec_pkg::SEV_UR_BIT] || next_action == tlpec_pkg::TLPEC_ACT_DROP;
		end
		else if (pkt_to_bridge && vendor1)
			next_action = tlpec_pkg::TLPEC_ACT_DROP;
		else if (ecrc_fail)
		begin
			next_type = tlpec_pkg::TLPEC_ERR_ECRC;
			next_log = 1'b1;
			next_unc = severity[tlpec_pkg::SEV_UC_BIT];
		end
	end

	// ----------------------------------------
	// outputs and status
	// ----------------------------------------
	// one-cycle error strobe
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			res_valid <= 1'b0;
			res_action <= 2'h0;
			err_valid <= 1'b0;
			err_type <= 3'h0;
			err_uncorrectable <= 1'b0;
			err_log_header <= 1'b0;
			err_count <= 16'h0000;
		end
		else
		begin
			res_valid <= pkt_valid;
			res_action <= pkt_valid ? next_action : 2'h0;
			err_valid <= pkt_valid && next_type != tlpec_pkg::TLPEC_ERR_NONE;
			err_type <= pkt_valid ? next_type : 3'h0;
			err_uncorrectable <= pkt_valid && next_unc;
			err_log_header <= pkt_valid && next_log;
			if (pkt_valid && next_type != tlpec_pkg::TLPEC_ERR_NONE)
				err_count <= err_count + 16'h0001;
		end
	end

	// set wins over a write-one clear
	logic mc_hit;
	logic clr_sts;
	assign mc_hit = pkt_valid && next_type == tlpec_pkg::TLPEC_ERR_MCAST_BLOCK;
	assign clr_sts = wr_go && hit(aw_addr, tlpec_pkg::ADDR_STATUS) && w_strb[0];

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			primary_sta <= 1'b0;
			secondary_sta <= 1'b0;
		end
		else
		begin
			if (mc_hit && !pkt_secondary)
				primary_sta <= 1'b1;
			else if (clr_sts && w_data[tlpec_pkg::STS_PRI_STA_BIT])
				primary_sta <= 1'b0;
			if (mc_hit && pkt_secondary)
				secondary_sta <= 1'b1;
			else if (clr_sts && w_data[tlpec_pkg::STS_SEC_STA_BIT])
				secondary_sta <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: dv/tlpec_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module tlpec_sva
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pkt_valid,
	input wire logic pkt_lower_err,
	input wire logic pkt_overflow,
	input wire logic res_valid,
	input wire logic [1:0] res_action,
	input wire logic err_valid,
	input wire logic [2:0] err_type,
	input wire logic err_uncorrectable,
	input wire logic err_log_header
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// result and error strobe
	// ----------------------------------------
	sequence s_dropped;
		!err_valid && res_action == 2'h1;
	endsequence
	property p_result;
		pkt_valid |=> res_valid;
	endproperty
	a_result: assert property (p_result) else $error("packet got no result");
	property p_quiet;
		!pkt_valid |=> !res_valid && !err_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("strobe without packet");
	property p_typed;
		err_valid |-> res_valid && err_type != 3'h0 && err_type < 3'h7;
	endproperty
	a_typed: assert property (p_typed) else $error("error strobe of no class");
	property p_lower;
		pkt_valid && pkt_lower_err |=> s_dropped;
	endproperty
	a_lower: assert property (p_lower) else $error("lower layer error not ignored");
	property p_ovf;
		pkt_valid && pkt_overflow && !pkt_lower_err |=> err_valid && err_type == 3'h2
			&& err_uncorrectable && !err_log_header && res_action == 2'h2;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow handled wrongly");
	property p_malf;
		err_valid && err_type == 3'h3 |-> err_uncorrectable && err_log_header && res_action == 2'h2;
	endproperty
	a_malf: assert property (p_malf) else $error("malformed handled wrongly");
	property p_mcast;
		err_valid && err_type == 3'h4 |-> err_uncorrectable && err_log_header && res_action == 2'h2;
	endproperty
	a_mcast: assert property (p_mcast) else $error("blocked multicast handled wrongly");
	property p_unexp;
		err_valid && err_type == 3'h1 |-> err_log_header && res_action == 2'h1;
	endproperty
	a_unexp: assert property (p_unexp) else $error("unexpected completion kept");
	c_ovf: cover property (pkt_valid && pkt_overflow);
	c_malf: cover property (err_valid && err_type == 3'h3);
	c_ur: cover property (err_valid && err_type == 3'h6);
endmodule

bind tlpec_checker tlpec_sva sva_u (.*);

`default_nettype wire

/* File: dv/tlpec_link_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tlpec_link_model #(
	parameter int FUNCS = 4
)
(
	input wire logic clk,
	output logic pkt_valid,
	output logic [2:0] pkt_fmt,
	output logic [4:0] pkt_type,
	output logic [2:0] pkt_tc,
	output logic [1:0] pkt_attr,
	output logic pkt_digest,
	output logic pkt_poisoned,
	output logic [9:0] pkt_length,
	output logic [3:0] pkt_last_be,
	output logic [7:0] pkt_msg_code,
	output logic [12:0] pkt_payload_bytes,
	output logic [12:0] pkt_total_bytes,
	output logic pkt_secondary,
	output logic pkt_downstream,
	output logic pkt_to_bridge,
	output logic [FUNCS-1:0] pkt_func,
	output logic pkt_lower_err,
	output logic pkt_cpl_unmatched,
	output logic pkt_overflow,
	output logic pkt_mcast_blocked,
	output logic pkt_msg_code_ok,
	output logic pkt_ecrc_bad
);
	// fmt and type: mem read, mem write, io write, cfg read, completion, data message
	localparam logic [7:0] KIND [6] = '{8'h00, 8'h40, 8'h42, 8'h04, 8'h0a, 8'h70};
	logic [71+FUNCS:0] f = '0;
	initial pkt_valid = 1'b0;
	assign {pkt_fmt, pkt_type, pkt_tc, pkt_attr, pkt_digest, pkt_poisoned, pkt_length,
		pkt_last_be, pkt_msg_code, pkt_payload_bytes, pkt_total_bytes, pkt_secondary,
		pkt_downstream, pkt_to_bridge, pkt_func, pkt_lower_err, pkt_cpl_unmatched,
		pkt_overflow, pkt_mcast_blocked, pkt_msg_code_ok, pkt_ecrc_bad} = f;

	// called just after an edge; faults lets the packet break formation
	task automatic send(inout integer s, input bit faults);
		logic [7:0] ft, code;
		logic [12:0] pay, tot;
		logic [9:0] len;
		logic [31:0] r, q;
		logic fl;
		r = $random(s);
		q = $random(s);
		ft = KIND[r[7:0] % 6];
		len = (ft == 8'h40 || ft == 8'h70) ? 10'(r[13:8]) + 10'h1 : 10'h1;
		pay = ft[6] ? {1'b0, len, 2'h0} : 13'h0;
		fl = faults && r[16:15] == 2'h0;
		pay = pay + ((fl && q[1:0] == 2'h0) ? 13'h4 : 13'h0);
		tot = (ft[5] ? 13'h10 : 13'h0c) + pay + (r[14] ? 13'h4 : 13'h0);
		tot = tot + ((fl && q[1:0] == 2'h1) ? 13'h4 : 13'h0);
		code = r[18] ? {7'h3f, r[19]} : r[27:20];
		// top fmt bit set breaks every fmt/type pair
		f <= {ft | {faults && r[16:15] == 2'h1 && r[31], 7'h00},
			(faults && q[4:2] == 3'h0) ? q[7:5] : 3'h0,
			(fl && q[1:0] == 2'h3) ? 2'h1 : 2'h0, r[14], faults && r[17] && q[11:8] == 4'h0,
			len + 10'(fl && q[1:0] == 2'h2), (fl && q[1:0] == 2'h3) ? 4'hf : 4'h0, code,
			pay, tot, q[30], ft != 8'h0a && q[31], r[17], FUNCS'(1) << (r[30:28] % FUNCS),
			faults && q[15:12] == 4'h0, faults && q[17:16] == 2'h0,
			faults && q[21:18] == 4'h0, faults && q[25:22] == 4'h0,
			!(faults && q[27:26] == 2'h0) || code[7:1] == 7'h3f, faults && q[29:28] == 2'h0};
		pkt_valid <= 1'b1;
		@(posedge clk);
	endtask

	// released fields turn over so nothing stale looks like a packet
	task automatic idle();
		pkt_valid <= 1'b0;
		f <= ~f;
	endtask
endmodule

`default_nettype wire

/* File: dv/tb_tlp_error_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_tlp_error_checker;
	localparam int FUNCS = 4;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, res_action, pkt_attr, sts = 2'h0;
	logic pkt_valid, pkt_digest, pkt_poisoned, pkt_secondary, pkt_downstream, pkt_to_bridge;
	logic pkt_lower_err, pkt_cpl_unmatched, pkt_overflow, pkt_mcast_blocked, pkt_msg_code_ok;
	logic pkt_ecrc_bad, res_valid, err_valid, err_uncorrectable, err_log_header, ecrc_port_enable;
	logic [2:0] pkt_fmt, pkt_tc, err_type;
	logic [4:0] pkt_type;
	logic [9:0] pkt_length;
	logic [3:0] pkt_last_be;
	logic [7:0] pkt_msg_code, e;
	logic [12:0] pkt_payload_bytes, pkt_total_bytes;
	logic [FUNCS-1:0] pkt_func;
	logic [31:0] ctl = tlpec_pkg::CONTROL_RESET, sev = tlpec_pkg::SEVERITY_RESET;
	logic pend = 1'b0;
	integer seed = 32'h8468, mismatches = 0, n_tests = 0, cycles = 0, cnt = 0;

	tlpec_checker #(.FUNCS(FUNCS)) dut_u (.*);
	tlpec_link_model #(.FUNCS(FUNCS)) link_u (.*);

	always #2.5 clk = ~clk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// register bus master
	// ----------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, 32'h0);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, exp);
		check("rresp", s_axi_rresp, 32'h0);
	endtask

	// ----------------------------------------
	// reference: {err, type, uncorrectable, log, action}
	// ----------------------------------------
	function automatic logic [7:0] predict();
		logic dat, iocfg, msg, vend, post, bad, ur, ok;
		int max_payload_size_field, len;
		logic [FUNCS-1:0] fen;
		dat = pkt_fmt[1];
		iocfg = pkt_type == tlpec_pkg::TYPE_IO || pkt_type == tlpec_pkg::TYPE_CFG0
			|| pkt_type == tlpec_pkg::TYPE_CFG1;
		msg = pkt_type[4:3] == 2'h2;
		vend = msg && pkt_msg_code[7:1] == 7'h3f;
		post = dat && !iocfg;
		max_payload_size_field = 128 << (ctl[2:0] > 3'h5 ? 5 : ctl[2:0]);
		len = pkt_length == 10'h0 ? 1024 : pkt_length;
		fen = sev[8 +: FUNCS];
		// legal pairs: messages 4dw, io/cfg/cpl 3dw, locked read no data
		ok = !pkt_fmt[2] && (pkt_type == tlpec_pkg::TYPE_MEM || msg && pkt_fmt[0]
			|| pkt_type == tlpec_pkg::TYPE_MEMLK && !pkt_fmt[1]
			|| (iocfg || pkt_type[4:1] == 4'h5) && !pkt_fmt[0]);
		bad = !ok || !ctl[4 + pkt_tc] || pkt_payload_bytes > max_payload_size_field
			|| dat && pkt_payload_bytes != len * 4
			|| pkt_digest && pkt_total_bytes != (pkt_fmt[0] ? 16 : 12) + pkt_payload_bytes + 4
			|| iocfg && (pkt_length != 10'h1 || pkt_tc != 3'h0 || pkt_attr != 2'h0
			|| pkt_last_be != 4'h0);
		ur = pkt_to_bridge && (msg && (pkt_msg_code == tlpec_pkg::MSG_VENDOR0 || !pkt_msg_code_ok)
			|| pkt_poisoned && (pkt_type == tlpec_pkg::TYPE_IO || pkt_type == 5'h0 && dat
			|| msg && dat && !vend) || ctl[12] && pkt_type[4:1] != 4'h5)
			|| ctl[14] && !ctl[13] && pkt_downstream;
		if (pkt_lower_err) return 8'h01;
		if (pkt_overflow) return 8'haa;
		if (bad) return 8'hbe;
		if (pkt_mcast_blocked) return 8'hce;
		if (pkt_cpl_unmatched && pkt_type == tlpec_pkg::TYPE_CPL) return {4'h9, sev[0], 3'h5};
		if (ur) return {4'he, post || sev[1], 1'b1, post ? 2'h1 : 2'h3};
		if (pkt_to_bridge && msg && pkt_msg_code == tlpec_pkg::MSG_VENDOR1) return 8'h01;
		if (pkt_digest && pkt_ecrc_bad && |(fen & pkt_func)) return {4'hd, sev[0], 3'h4};
		return 8'h00;
	endfunction

	always @(posedge clk)
	begin
		cycles++;
		if (pend)
		begin
			check("res_valid", res_valid, 1'b1);
			check("res_action", res_action, e[1:0]);
			check("err_valid", err_valid, e[7]);
			if (e[7]) check("err_info", {err_type, err_uncorrectable, err_log_header}, e[6:2]);
		end
		else if (reset_n) check("strobe_idle", {res_valid, err_valid}, 2'h0);
		pend = reset_n && pkt_valid;
		if (pend)
		begin
			e = predict();
			cnt += e[7];
			if (e[7:4] == 4'hc) sts[pkt_secondary] = 1'b1;
		end
		if (cycles == 20000)
		begin
			mismatches++;
			final_report();
		end
	end

	initial
	begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		axi_rd(tlpec_pkg::ADDR_CONTROL, tlpec_pkg::CONTROL_RESET);
		axi_rd(tlpec_pkg::ADDR_SEVERITY, tlpec_pkg::SEVERITY_RESET);
		axi_rd(tlpec_pkg::ADDR_COUNT, 32'h0);
		axi_wr(8'h10, 32'hffff_ffff);
		axi_rd(8'h10, 32'h0);
		for (int b = 0; b < 8; b++)
		begin
			// d3hot, then link down, then link up on a downstream port
			ctl = {17'h0, b > 5, b != 6, b == 5, 8'($random(seed)) | 8'h01, 1'b0, 3'($random(seed))};
			sev = {20'h0, 4'($random(seed)), 6'h0, 2'($random(seed))};
			axi_wr(tlpec_pkg::ADDR_CONTROL, ctl);
			axi_wr(tlpec_pkg::ADDR_SEVERITY, sev);
			axi_rd(tlpec_pkg::ADDR_CONTROL, ctl);
			axi_rd(tlpec_pkg::ADDR_SEVERITY, sev);
			check("ecrc_port_enable", ecrc_port_enable, |sev[11:8]);
			repeat (60) link_u.send(seed, b != 0);
			link_u.idle();
			// last packet is checked at this edge, one after its prediction; ctl and sev must not move before that
			@(posedge clk);
			$display("batch %0d done", b);
		end
		axi_rd(tlpec_pkg::ADDR_STATUS, {30'h0, sts});
		axi_wr(tlpec_pkg::ADDR_STATUS, 32'h3);
		axi_rd(tlpec_pkg::ADDR_STATUS, 32'h0);
		axi_rd(tlpec_pkg::ADDR_COUNT, cnt);
		final_report();
	end
endmodule

`default_nettype wire
